// >>> bench/crt_raster_properties.sv
// link assertions between the bus party and the raster device
`timescale 1ns/100ps
`default_nettype none
module crt_raster_props (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // link signals
    input  wire logic       cs,
    input  wire logic [3:0] reg_addr,
    input  wire logic       transfer_strobe,
    input  wire logic [7:0] host_drv,
    input  wire logic       host_oe,
    input  wire logic [7:0] dev_drv,
    input  wire logic       dev_oe,
    input  wire logic [7:0] host_bus_lines
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // strobe framing: select must surround every strobe
    a_strobe_needs_cs: assert property (transfer_strobe |-> cs)
        else $error("strobe without chip select");
    a_cs_leads_strobe: assert property ($rose(transfer_strobe)
        |-> $past(cs))
        else $error("chip select not set before strobe");
    a_cs_trails_strobe: assert property (transfer_strobe |=> cs)
        else $error("chip select dropped with strobe");
    a_strobe_one_cycle: assert property (transfer_strobe
        |=> !transfer_strobe)
        else $error("strobe longer than one cycle");
    a_addr_held: assert property (cs && $past(cs) |-> $stable(reg_addr))
        else $error("register address moved while selected");
    // bus direction: device drives only for cursor reads
    a_no_bus_fight: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the data lines");
    a_host_oe_sel: assert property (host_oe |-> cs)
        else $error("host drives while deselected");
    a_write_driven: assert property (transfer_strobe
        && !(reg_addr inside {4'h8, 4'h9}) |-> host_oe)
        else $error("load strobe without host data");
    a_read_only_drive: assert property ($rose(dev_oe) |->
        $past(cs) && $past(reg_addr) inside {4'h8, 4'h9})
        else $error("device drives outside a cursor read");
    a_read_answer: assert property ($rose(cs)
        && reg_addr inside {4'h8, 4'h9} |-> ##[1:3] dev_oe)
        else $error("cursor read never answered");
    a_drive_release: assert property (dev_oe |-> cs || $past(cs))
        else $error("device kept driving after deselect");

    c_load: cover property (transfer_strobe && host_oe);
    c_read: cover property ($rose(dev_oe));
    c_start: cover property (transfer_strobe && reg_addr == 4'he);
endmodule
`default_nettype wire

// >>> bench/tb_crt_raster_timing_pins.sv
// self-checking bench: AHB host end driving the raster device end
`timescale 1ns/100ps
`default_nettype none
`include "crt_cfg.svh"
module tb_crt_raster_timing_pins
    import crt_pkg::*;
;
    logic        clk, rst_n, tick, hsel, hwrite, hreadyout, hresp;
    logic [1:0]  tdiv, htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [6:0]  char_cnt, hs_at, hs0;
    logic [2:0]  font_row;
    logic [4:0]  text_row;
    logic        scan_lsb, shared_msb, blank, lsync, fsync, csync, cursor;
    logic        mon_on, meas_on, ilace, lsync_d;
    logic [7:0]  ctl [7] = '{8'h1f, 8'h10, 8'h73, 8'h00, 8'h10, 8'h18, 8'h17};
    int          err_total, tests_run, cycles, seed, tot, cur_c, cur_r;
    int          n_vs, n_hs, n_cur, vs_len, hs_len;

    crt_link_if crt_link_if_i ();
    crt_raster_dev crt_raster_dev_i (.CLK(clk), .RST_N(rst_n),
        .CHAR_RATE_TICK(tick), .link(crt_link_if_i),
        .CHAR_COUNT_OUT(char_cnt), .FONT_ROW_SELECT(font_row),
        .SCAN_LSB_OUT(scan_lsb), .SHARED_MSB_OUT(shared_msb),
        .TEXT_ROW_OUT(text_row), .BLANKING_OUT(blank),
        .LINE_SYNC_OUT(lsync), .FRAME_SYNC_OUT(fsync),
        .COMBINED_SYNC_OUT(csync), .CURSOR_MARKER_OUT(cursor));
    crt_raster_host crt_raster_host_i (.CLK(clk), .RST_N(rst_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .link(crt_link_if_i));
    crt_raster_props crt_raster_props_i (.CLK(clk), .RST_N(rst_n),
        .cs(crt_link_if_i.cs), .reg_addr(crt_link_if_i.reg_addr),
        .transfer_strobe(crt_link_if_i.transfer_strobe),
        .host_drv(crt_link_if_i.host_drv), .host_oe(crt_link_if_i.host_oe),
        .dev_drv(crt_link_if_i.dev_drv), .dev_oe(crt_link_if_i.dev_oe),
        .host_bus_lines(crt_link_if_i.host_bus_lines));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one AHB single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    // order to the device, then poll busy so the next one is not dropped
    task automatic cmd(input logic [3:0] code, input logic [7:0] data);
        int n;
        xfer(1'b1, `CRT_OFF_CMD, {20'h0, code, data}, rd);
        n = 0;
        rd = 32'h1;
        while (rd[`CRT_STAT_BUSY] !== 1'b0 && n < 40) begin
            xfer(1'b0, `CRT_OFF_STAT, 32'h0, rd);
            n++;
        end
        xfer(1'b0, `CRT_OFF_STAT, 32'h0, rd);
    endtask

    // follow the character counter against an integer model
    task automatic track(input int ticks);
        int mc;
        int n;
        logic [6:0] last;
        @(posedge clk);
        mc = char_cnt;
        for (int k = 0; k < ticks; k++) begin
            last = char_cnt;
            n = 0;
            while (char_cnt === last && n < 20) begin
                @(posedge clk);
                n++;
            end
            mc = (mc + 1) % (tot + 1);
            check(char_cnt, mc[6:0]);
            if (k != 0) check(n, 4);
            if (tot >= 128) check(shared_msb, mc >= 128);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // dot counter carry: one cycle high in four
    always @(posedge clk) begin
        tdiv <= tdiv + 2'd1;
        tick <= (tdiv == 2'd3);
        cycles++;
        if (cycles == 90000) begin
            err_total++;
            give_verdict;
        end
    end

    // per-cycle watch; widths counted in clocks, four per character
    always @(posedge clk) begin
        if (mon_on) begin
            if (lsync === 1'b1 || fsync === 1'b1) check(blank, 1'b1);
            check(csync, ilace ? 1'b0 : lsync ^ fsync);
            if (lsync === 1'b1 && lsync_d !== 1'b1) hs_at = char_cnt;
            lsync_d = lsync;
        end
        if (meas_on) begin
            if (cursor === 1'b1) begin
                check(char_cnt, cur_c[6:0]);
                check(text_row, cur_r[4:0]);
                check({font_row, scan_lsb}, (n_cur / 4) % 8);
                n_cur++;
            end
            if (fsync === 1'b1) vs_len++;
            else if (vs_len != 0) begin
                if (n_vs != 0) check(vs_len, 3 * (tot + 1) * 4);
                n_vs++;
                vs_len = 0;
            end
            if (lsync === 1'b1) hs_len++;
            else if (hs_len != 0) begin
                if (n_hs != 0) check(hs_len, 3 * 4);
                n_hs++;
                hs_len = 0;
            end
        end
    end

    initial begin
        {rst_n, tick, hsel, hwrite, htrans, haddr, hwdata, tdiv} = '0;
        {mon_on, meas_on, ilace, lsync_d} = '0;
        {err_total, tests_run, cycles, n_vs, n_hs, n_cur} = '0;
        {vs_len, hs_len, hs_at} = '0;
        seed = 94112;
        tot = 31;
        repeat (8) @(posedge clk);
        check(blank, 1'b1);
        check(char_cnt, 7'h00);
        check(hreadyout, 1'b1);
        check(crt_link_if_i.cs, 1'b0);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cur_c = ($random(seed) & 32'h7fff) % 20;
        cur_r = ($random(seed) & 32'h7fff) % 24;
        cmd(`CRT_A_LD_CHAR, cur_c[7:0]);
        cmd(`CRT_A_LD_LINE, cur_r[7:0]);
        xfer(1'b0, `CRT_OFF_CMD, 32'h0, rd);
        check(rd, {20'h0, `CRT_A_LD_LINE, cur_r[7:0]});
        cmd(`CRT_A_RD_CHAR, 8'h00);
        check(rd[15:8], cur_c[7:0]);
        cmd(`CRT_A_RD_LINE, 8'h00);
        check(rd[15:8], cur_r[7:0]);
        xfer(1'b0, 8'h08, 32'h0, rd);
        check(rd, 32'h0);
        check(hresp, 1'b0);
        // second order lands while busy and must be dropped
        xfer(1'b1, `CRT_OFF_CMD, {20'h0, `CRT_A_LD_CHAR, 8'h55}, rd);
        cmd(`CRT_A_LD_CHAR, 8'h66);
        cmd(`CRT_A_RD_CHAR, 8'h00);
        check(rd[15:8], 8'h55);
        cmd(`CRT_A_LD_CHAR, cur_c[7:0]);
        cmd(`CRT_A_RESET, 8'h00);
        for (int i = 0; i < 7; i++) begin
            cmd(i[3:0], ctl[i]);
        end
        repeat (40) @(posedge clk);
        check(char_cnt, 7'h00);
        meas_on = 1'b1;
        cmd(`CRT_A_START, 8'h00);
        mon_on = 1'b1;
        track(60);
        while (n_vs < 2) @(posedge clk);
        meas_on = 1'b0;
        check(n_cur, 2 * 8 * 4);
        hs0 = hs_at;
        cmd(4'h1, 8'h90);
        repeat (400) @(posedge clk);
        check(hs_at, hs0 + 7'd2);
        cmd(4'h0, 8'h9f);
        tot = 159;
        track(200);
        mon_on = 1'b0;
        cmd(4'h5, 8'h98);
        ilace = 1'b1;
        repeat (4) @(posedge clk);
        mon_on = 1'b1;
        repeat (3000) @(posedge clk);
        give_verdict;
    end
endmodule
`default_nettype wire

// >>> logic/crt_raster_dev.sv
// raster timing device: control words, counters, sync, blank, cursor
// What this block does
// R1: each strobe loads a register or reads cursor
// R2: bus driven only for cursor address reads
// R3: transfers honoured only while chip select high
// R4: host gives four-bit register address per transfer
// R5: all character-rate logic advances on tick
// R6: shared pin: counter MSB if total >=128
// R7: scan counter top bits select font row
// R8: scan LSB on own pin, field bit interlaced
// R9: odd field odd scans, even field even
// R10: low five row counter bits driven out
// R11: blank during horizontal and vertical retrace
// R12: composite sync only when not interlaced
// R13: cursor marker at programmed char and row
// R14: line and frame sync start each retrace
// R15: frame sync lasts exactly three line periods
// R16: skew delays blank, syncs, cursor 0-2 chars
// R17: interlace bit one selects odd/even fields
`timescale 1ns/100ps
`default_nettype none
`include "crt_cfg.svh"
module crt_raster_dev
    import crt_pkg::*;
#(
    parameter int NREG = 7
) (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // dot counter carry
    input  wire logic       CHAR_RATE_TICK,
    // bus pins
    crt_link_if.dev         link,
    // counter outputs
    output logic [6:0]      CHAR_COUNT_OUT,
    output logic [2:0]      FONT_ROW_SELECT,
    output logic            SCAN_LSB_OUT,
    output logic            SHARED_MSB_OUT,
    output logic [4:0]      TEXT_ROW_OUT,
    // video timing outputs
    output logic            BLANKING_OUT,
    output logic            LINE_SYNC_OUT,
    output logic            FRAME_SYNC_OUT,
    output logic            COMBINED_SYNC_OUT,
    output logic            CURSOR_MARKER_OUT
);
    // cursor read addresses are the only ones that turn the bus round
    function automatic logic is_read(input crt_addr_t a);
        return (a == `CRT_A_RD_LINE) || (a == `CRT_A_RD_CHAR);
    endfunction

    // mask-style character length table
    function automatic logic [7:0] row_chars(input logic [2:0] c);
        unique case (c)
            3'h0: return 8'h14;
            3'h1: return 8'h20;
            3'h2: return 8'h28;
            3'h3: return 8'h40;
            3'h4: return 8'h48;
            3'h5: return 8'h50;
            3'h6: return 8'h60;
            3'h7: return 8'h84;
        endcase
    endfunction

    crt_byte_t  ctl_r [NREG];
    crt_byte_t  cur_char_r;
    crt_byte_t  cur_line_r;
    logic [5:0] top_r;
    logic       run_r;
    logic       tick_d_r;
    logic [7:0] hc_r;
    logic [9:0] ln_r;
    logic [9:0] fl_r;
    logic [9:0] vs_cnt_r;
    logic       field_r;
    logic       vact_r;
    logic [3:0] scan_r;
    logic [5:0] row_r;
    logic [5:0] rows_left_r;
    logic [3:0] pipe_r [2];
    crt_byte_t  dev_drv_r;
    logic       dev_oe_r;

    // field views of the control words
    logic [7:0] htot;
    logic [7:0] hact;
    logic [2:0] hsd;
    logic [1:0] skew;
    logic [3:0] hsw;
    logic [3:0] spr;
    logic       ilace;
    logic [9:0] ftot;
    logic [8:0] hs_beg;
    logic [8:0] hs_end;
    assign htot   = ctl_r[`CRT_R_HTOT];
    assign hact   = row_chars(ctl_r[`CRT_R_HFMT][`CRT_F_CODE_LO +: 3]);
    assign hsd    = ctl_r[`CRT_R_HFMT][`CRT_F_HSD_LO +: 3];
    assign skew   = ctl_r[`CRT_R_HFMT][`CRT_F_SKEW_LO +: 2];
    assign hsw    = ctl_r[`CRT_R_HSW][`CRT_F_HSW_LO +: 4];
    assign spr    = ctl_r[`CRT_R_HSW][`CRT_F_SPR_LO +: 4];
    assign ilace  = ctl_r[`CRT_R_ROWS][`CRT_F_ILACE]; // R17
    assign ftot   = {1'b0, ctl_r[`CRT_R_SFX], 1'b0} +
                    (ilace ? `CRT_BASE_ILACE : `CRT_BASE_PROG);
    assign hs_beg = {1'b0, hact} + {6'h00, hsd};
    assign hs_end = hs_beg + {5'h00, hsw};

    // bus decode; a strobe without chip select is ignored
    logic take;
    logic wr_ctl;
    assign take   = link.transfer_strobe & link.cs; // R3
    assign wr_ctl = take & ~link.reg_addr[3] &
                    (link.reg_addr != `CRT_A_SELF_PROC); // R1

    // character tick edge; every count below moves only on it
    logic adv;
    logic line_end;
    logic vs_go;
    logic fl_hit;
    logic start_rows;
    assign adv      = CHAR_RATE_TICK & ~tick_d_r & run_r; // R5
    assign line_end = adv & (hc_r == htot);
    // second field sync starts mid-line to split the frame in half
    assign vs_go    = (line_end & (ln_r == ftot - 10'd1)) |
                      (adv & ilace & (ln_r == {1'b0, ftot[9:1]}) &
                       (hc_r == {1'b0, htot[7:1]})); // R14
    assign fl_hit   = (fl_r + 10'd1) == {2'h0, ctl_r[`CRT_R_VDS]};
    assign start_rows = (vs_go & (ctl_r[`CRT_R_VDS] == 8'h00)) |
                        (line_end & ~vs_go & fl_hit);

    // control words, cursor, scroll and run state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_r[`CRT_R_HTOT] <= `CRT_RST_HTOT;
            ctl_r[`CRT_R_HFMT] <= `CRT_RST_HFMT;
            ctl_r[`CRT_R_HSW]  <= `CRT_RST_HSW;
            ctl_r[`CRT_R_SFX]  <= `CRT_RST_SFX;
            ctl_r[`CRT_R_VDS]  <= `CRT_RST_VDS;
            ctl_r[`CRT_R_ROWS] <= `CRT_RST_ROWS;
            ctl_r[`CRT_R_LAST] <= `CRT_RST_LAST;
            cur_char_r <= 8'h00;
            cur_line_r <= 8'h00;
            top_r      <= 6'h00;
            run_r      <= 1'b1;
        end else if (take) begin
            if (wr_ctl) begin
                ctl_r[link.reg_addr[2:0]] <= link.host_bus_lines; // R1
            end
            unique case (link.reg_addr)
                `CRT_A_LD_CHAR: cur_char_r <= link.host_bus_lines;
                `CRT_A_LD_LINE: cur_line_r <= link.host_bus_lines;
                `CRT_A_RESET:   run_r <= 1'b0;
                `CRT_A_START:   run_r <= 1'b1;
                `CRT_A_SCROLL:  top_r <= (top_r == ctl_r[`CRT_R_LAST][5:0])
                                         ? 6'h00 : top_r + 6'h01;
                default: ;
            endcase
        end
    end

    // read-back driver; registered so the turn-round lags chip select
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dev_oe_r  <= 1'b0;
            dev_drv_r <= 8'h00;
        end else begin
            dev_oe_r  <= link.cs & ~link.host_oe &
                         is_read(link.reg_addr); // R2
            dev_drv_r <= (link.reg_addr == `CRT_A_RD_LINE) ?
                         cur_line_r : cur_char_r; // R1
        end
    end
    assign link.dev_oe  = dev_oe_r;
    assign link.dev_drv = dev_drv_r;

    // character counter; reset holds the chain at top left
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_d_r <= 1'b0;
            hc_r     <= 8'h00;
        end else begin
            tick_d_r <= CHAR_RATE_TICK;
            if (!run_r) begin
                hc_r <= 8'h00;
            end else if (adv) begin
                hc_r <= line_end ? 8'h00 : hc_r + 8'h01; // R5
            end
        end
    end

    // frame and field line counters
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ln_r <= 10'h000;
            fl_r <= 10'h000;
        end else if (!run_r) begin
            ln_r <= 10'h000;
            fl_r <= 10'h000;
        end else begin
            if (line_end) begin
                ln_r <= (ln_r == ftot - 10'd1) ? 10'h000 : ln_r + 10'h001;
            end
            if (vs_go) begin
                fl_r <= 10'h000;
            end else if (line_end) begin
                fl_r <= fl_r + 10'h001;
            end
        end
    end

    // frame sync length counted in characters so a mid-line start works
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            vs_cnt_r <= 10'h000;
            field_r  <= 1'b0;
        end else if (!run_r) begin
            vs_cnt_r <= 10'h000;
            field_r  <= 1'b0;
        end else if (vs_go) begin
            vs_cnt_r <= 10'(`CRT_VS_LINES * ({2'h0, htot} + 10'd1)); // R15
            field_r  <= ilace ? ~field_r : 1'b0; // R17
        end else if (adv && vs_cnt_r != 10'h000) begin
            vs_cnt_r <= vs_cnt_r - 10'h001;
        end
    end

    // data rows and scans; interlace steps two scans from the field bit
    logic [4:0] scan_nxt;
    assign scan_nxt = {1'b0, scan_r} + (ilace ? 5'h02 : 5'h01);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            vact_r      <= 1'b0;
            scan_r      <= 4'h0;
            row_r       <= 6'h00;
            rows_left_r <= 6'h00;
        end else if (!run_r || vs_go) begin
            vact_r <= start_rows;
            scan_r <= {3'h0, ilace & ~field_r};
            row_r  <= top_r;
            rows_left_r <= ctl_r[`CRT_R_ROWS][5:0];
        end else if (start_rows) begin
            vact_r      <= ctl_r[`CRT_R_ROWS][5:0] != 6'h00;
            scan_r      <= {3'h0, ilace & field_r}; // R9
            row_r       <= top_r;
            rows_left_r <= ctl_r[`CRT_R_ROWS][5:0];
        end else if (line_end && vact_r) begin
            if (scan_nxt > {1'b0, spr}) begin
                scan_r <= {3'h0, ilace & field_r}; // R9
                row_r  <= (row_r == ctl_r[`CRT_R_LAST][5:0]) ?
                          6'h00 : row_r + 6'h01;
                rows_left_r <= rows_left_r - 6'h01;
                vact_r <= rows_left_r != 6'h01;
            end else begin
                scan_r <= scan_nxt[3:0];
            end
        end
    end

    // raw timing {blank, hsync, vsync, cursor} before skew
    logic hact_on;
    logic [3:0] raw;
    logic [3:0] sel;
    assign hact_on = hc_r < hact;
    assign raw[3] = ~(hact_on & vact_r); // R11
    assign raw[2] = ({1'b0, hc_r} >= hs_beg) &
                    ({1'b0, hc_r} < hs_end); // R14
    assign raw[1] = vs_cnt_r != 10'h000; // R15
    assign raw[0] = vact_r & hact_on & (hc_r == cur_char_r) &
                    (row_r == cur_line_r[5:0]); // R13

    // skew line: code 3 behaves as 2, the deepest tap there is
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pipe_r[0] <= 4'h8;
            pipe_r[1] <= 4'h8;
        end else if (adv) begin
            pipe_r[0] <= raw;
            pipe_r[1] <= pipe_r[0];
        end
    end
    assign sel = (skew == 2'h0) ? raw :
                 (skew == 2'h1) ? pipe_r[0] : pipe_r[1]; // R16

    // every pin comes straight from a flop
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CHAR_COUNT_OUT    <= 7'h00;
            FONT_ROW_SELECT   <= 3'h0;
            SCAN_LSB_OUT      <= 1'b0;
            SHARED_MSB_OUT    <= 1'b0;
            TEXT_ROW_OUT      <= 5'h00;
            BLANKING_OUT      <= 1'b1;
            LINE_SYNC_OUT     <= 1'b0;
            FRAME_SYNC_OUT    <= 1'b0;
            COMBINED_SYNC_OUT <= 1'b0;
            CURSOR_MARKER_OUT <= 1'b0;
        end else begin
            CHAR_COUNT_OUT    <= hc_r[6:0];
            FONT_ROW_SELECT   <= scan_r[3:1]; // R7
            SCAN_LSB_OUT      <= scan_r[0]; // R8
            SHARED_MSB_OUT    <= htot[7] ? hc_r[7] : row_r[5]; // R6
            TEXT_ROW_OUT      <= row_r[4:0]; // R10
            BLANKING_OUT      <= sel[3];
            LINE_SYNC_OUT     <= sel[2];
            FRAME_SYNC_OUT    <= sel[1];
            // serrated during frame sync by inverting the line pulse
            COMBINED_SYNC_OUT <= ~ilace & (sel[1] ^ sel[2]); // R12
            CURSOR_MARKER_OUT <= sel[0];
        end
    end
endmodule
`default_nettype wire

// >>> logic/crt_raster_host.sv
// bus party: AHB-Lite slave that runs transfers on the device pins
`timescale 1ns/100ps
`default_nettype none
`include "crt_cfg.svh"
module crt_raster_host
    import crt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // device pins
    crt_link_if.host         link
);
    crt_hstate_e state_r;
    crt_addr_t   addr_r;
    crt_byte_t   wdat_r;
    crt_byte_t   rdat_r;
    logic        wr_pend_r;
    logic        go;
    logic        busy;

    assign busy = state_r != CRT_H_IDLE;
    // a new command while busy is dropped, not queued
    assign go = wr_pend_r & ~busy;

    // address phase capture; zero-wait, data read out next cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_r <= 1'b0;
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            wr_pend_r <= 1'b0;
            if (HSEL && HTRANS[1] && HREADY) begin
                wr_pend_r <= HWRITE && (HADDR[7:0] == `CRT_OFF_CMD);
                if (HWRITE) begin
                    HRDATA <= 32'h0000_0000;
                end else if (HADDR[7:0] == `CRT_OFF_CMD) begin
                    HRDATA <= {20'h00000, addr_r, wdat_r};
                end else if (HADDR[7:0] == `CRT_OFF_STAT) begin
                    HRDATA <= {16'h0000, rdat_r, 7'h00, busy};
                end else begin
                    HRDATA <= 32'h0000_0000;
                end
            end
        end
    end

    // transfer sequence: setup, strobe, hold, one clock each
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= CRT_H_IDLE;
            addr_r  <= 4'h0;
            wdat_r  <= 8'h00;
            rdat_r  <= 8'h00;
        end else begin
            unique case (state_r)
                CRT_H_IDLE: begin
                    if (go) begin
                        addr_r  <= HWDATA[`CRT_CMD_ADDR_LO +: 4]; // R4
                        wdat_r  <= HWDATA[7:0];
                        state_r <= CRT_H_SETUP;
                    end
                end
                CRT_H_SETUP:  state_r <= CRT_H_STROBE;
                CRT_H_STROBE: state_r <= CRT_H_HOLD;
                CRT_H_HOLD: begin
                    if (link.dev_oe) begin
                        rdat_r <= link.host_bus_lines; // R1
                    end
                    state_r <= CRT_H_IDLE;
                end
            endcase
        end
    end

    // pin drivers, all from flops
    logic cs_r;
    logic stb_r;
    logic oe_r;
    logic rd_addr;
    assign rd_addr = (addr_r == `CRT_A_RD_LINE) ||
                     (addr_r == `CRT_A_RD_CHAR);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_r  <= 1'b0;
            stb_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            cs_r  <= (state_r == CRT_H_IDLE) ? go :
                     (state_r != CRT_H_HOLD); // R3
            stb_r <= state_r == CRT_H_SETUP; // R1
            oe_r  <= (state_r == CRT_H_IDLE) ?
                     go & ~((HWDATA[`CRT_CMD_ADDR_LO +: 4] ==
                             `CRT_A_RD_LINE) ||
                            (HWDATA[`CRT_CMD_ADDR_LO +: 4] ==
                             `CRT_A_RD_CHAR)) :
                     (state_r != CRT_H_HOLD) & ~rd_addr; // R2
        end
    end
    assign link.cs              = cs_r;
    assign link.transfer_strobe = stb_r;
    assign link.host_oe         = oe_r;
    assign link.reg_addr        = addr_r;
    assign link.host_drv        = wdat_r;
endmodule
`default_nettype wire

// >>> pkg/crt_cfg.svh
// constants for the raster timing block: codes, field positions, counts
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH

// register address / command codes on the four address lines
`define CRT_A_SELF_PROC  4'h7
`define CRT_A_RD_LINE    4'h8
`define CRT_A_RD_CHAR    4'h9
`define CRT_A_RESET      4'ha
`define CRT_A_SCROLL     4'hb
`define CRT_A_LD_CHAR    4'hc
`define CRT_A_LD_LINE    4'hd
`define CRT_A_START      4'he
`define CRT_A_SELF_NP    4'hf

// control word field positions (register index, bits)
`define CRT_R_HTOT       0
`define CRT_R_HFMT       1
`define CRT_R_HSW        2
`define CRT_R_SFX        3
`define CRT_R_VDS        4
`define CRT_R_ROWS       5
`define CRT_R_LAST       6
`define CRT_F_CODE_LO    0
`define CRT_F_HSD_LO     3
`define CRT_F_SKEW_LO    6
`define CRT_F_HSW_LO     0
`define CRT_F_SPR_LO     4
`define CRT_F_ILACE      7

// control word reset values
`define CRT_RST_HTOT     8'h63
`define CRT_RST_HFMT     8'h15
`define CRT_RST_HSW      8'hb9
`define CRT_RST_SFX      8'h03
`define CRT_RST_VDS      8'h10
`define CRT_RST_ROWS     8'h18
`define CRT_RST_LAST     8'h17

// vertical timing
`define CRT_VS_LINES     10'd3
`define CRT_BASE_ILACE   10'd513
`define CRT_BASE_PROG    10'd256

// host register offsets on the system bus
`define CRT_OFF_CMD      8'h00
`define CRT_OFF_STAT     8'h04
`define CRT_CMD_ADDR_LO  8
`define CRT_STAT_BUSY    0
`define CRT_STAT_RD_LO   8

`endif

// >>> pkg/crt_link_if.sv
// pin bundle between the bus party and the raster timing device
`timescale 1ns/100ps
`default_nettype none
interface crt_link_if;
    logic       cs;
    logic [3:0] reg_addr;
    logic       transfer_strobe;
    logic [7:0] host_drv;
    logic       host_oe;
    logic [7:0] dev_drv;
    logic       dev_oe;
    logic [7:0] host_bus_lines;

    // resolved bus level; idle bus floats high
    assign host_bus_lines = host_oe ? host_drv :
                            dev_oe  ? dev_drv  : 8'hff;

    modport host (output cs, output reg_addr, output transfer_strobe,
                  output host_drv, output host_oe,
                  input dev_oe, input host_bus_lines);
    modport dev  (input cs, input reg_addr, input transfer_strobe,
                  output dev_drv, output dev_oe,
                  input host_oe, input host_bus_lines);
endinterface
`default_nettype wire

// >>> pkg/crt_pkg.sv
// types shared by the two ends of the raster timing link
package crt_pkg;
    typedef logic [7:0] crt_byte_t;
    typedef logic [3:0] crt_addr_t;
    typedef enum logic [1:0] {
        CRT_H_IDLE,
        CRT_H_SETUP,
        CRT_H_STROBE,
        CRT_H_HOLD
    } crt_hstate_e;
endpackage
